// [include/sbc_regs.vh]
/*
 Register offsets, field positions and timing counts of the charge-control block.
 Assumes inclusion by the charge-control design file only.
*/
`ifndef SBC_REGS_VH
`define SBC_REGS_VH
`define SBC_CYCLE_INIT 8'h0C
`define SBC_PACK_OPT 8'h28
`define SBC_GAUGE_OPT 8'h29
`define SBC_CYCLE_THR 8'h37
`define SBC_CHG_VOLT 8'h39
`define SBC_PRE_VOLT 8'h3B
`define SBC_FAST_RATE 8'h3D
`define SBC_MAINT_RATE 8'h3F
`define SBC_PRE_RATE 8'h41
`define SBC_PRE_TEMP 8'h43
`define SBC_TERM_PCT 8'h46
`define SBC_FULL_CLR_PCT 8'h47
`define SBC_TAPER_CUR 8'h48
`define SBC_TAPER_QUAL 8'h4A
`define SBC_OVERCHG 8'h4E
`define SBC_CHG_TEMP 8'h53
`define SBC_TEMP_HYST 8'h55
`define SBC_OV_MARGIN 8'h5A
`define SBC_OC_MARGIN 8'h5C
`define SBC_CELL_HIGH 8'h60
`define SBC_CELL_LOW 8'h62
`define SBC_SAFE_VOLT 8'h68
`define SBC_SAFE_TEMP 8'h6A
`define SBC_CELL_LOW_REL 8'hD1
`define SBC_BAL_START 8'hD9
`define SBC_BAL_MIN 8'hDB
`define SBC_BAL_PERIOD 8'hDC
`define SBC_CELL_HIGH_REL 8'hEF
`define SBC_EOD_THR 8'hF0
`define SBC_STATUS 8'hF1
`define SBC_CYCLE_CNT 8'hF2
`define SBC_REQ_CUR 8'hF3
`define SBC_PACK_DISPLAY_SOURCE_SELECT 7
`define SBC_PACK_LED_COUNT_HIGH 6
`define SBC_PACK_LED_COUNT_LOW 5
`define SBC_PACK_HPE 4
`define SBC_PACK_CPE 3
`define SBC_PACK_SM 2
`define SBC_GAUGE_CAPACITY_SYNC_ON_TERMINATION 6
`define SBC_GAUGE_EOD_COMPENSATION_ENABLE 4
`define SBC_GAUGE_OVERVOLTAGE_BASIS_SELECT 2
`define SBC_TEMP_FLOOR 16'h01AE
`define SBC_BAL_OFF 16'hFFFF
`define SBC_CLK_MHZ 200
`define SBC_TICK_CYCLES (`SBC_CLK_MHZ * 1000000)
`define SBC_TAPER_SEC 40
`endif

// [src/sbc_charge_ctrl.v]
/*
 Charge-control and pack-option logic of a smart-battery gauge: current request,
 suspension, termination, capacity sync, cycle count and option decode.
 Assumes measurements arrive from logic on sys_clk; capacity updates are pulses.
*/
`timescale 1ns/1ps
`include "sbc_regs.vh"
module sbc_charge_ctrl
#(
    parameter TICK_CYCLES = `SBC_TICK_CYCLES
)
(
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // Register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Measurements
    input wire [15:0] pack_voltage,
    input wire [15:0] pack_current,
    input wire charging,
    input wire signed [15:0] temperature,
    input wire [15:0] highest_cell_voltage,
    input wire [15:0] lowest_cell_voltage,
    input wire [15:0] computed_eod_threshold,
    input wire [15:0] full_charge_capacity,
    input wire [7:0] relative_soc,
    input wire [7:0] absolute_soc,
    input wire [15:0] charge_past_full,
    input wire [15:0] discharged_mah,
    input wire fast_term_event,
    input wire full_set_event,
    // Charger requests
    output reg [15:0] charge_voltage_request,
    output reg [15:0] charge_current_request,
    // Capacity sync
    output reg remaining_capacity_load,
    output reg [15:0] remaining_capacity,
    // Status
    output reg fully_charged,
    output reg [15:0] cycle_count,
    output reg balance_start,
    output reg safety_overvoltage,
    output wire overvoltage_suspend,
    output wire overtemp_suspend,
    output wire overcurrent_suspend,
    output wire overcharge_suspend,
    output wire taper_terminated,
    // Pack and gauge options
    output wire display_source_select,
    output wire [2:0] led_count,
    output wire host_alarm_crc_enable,
    output wire charger_broadcast_crc_enable,
    output wire broadcast_enable,
    output wire [2:0] series_cells,
    output wire [15:0] eod_threshold
);

// ----------------------------------------
// Register file
// ----------------------------------------
reg [15:0] cycle_init_reg, cycle_thr_reg, chg_volt_reg, pre_volt_reg;
reg [15:0] fast_rate_reg, maint_rate_reg, pre_rate_reg, taper_cur_reg;
reg [15:0] overchg_reg, chg_temp_reg, ov_margin_reg, oc_margin_reg;
reg [15:0] cell_high_reg, cell_low_reg, safe_volt_reg, safe_temp_reg;
reg [15:0] cell_low_rel_reg, bal_start_reg, eod_thr_reg;
reg [7:0] pack_opt_reg, gauge_opt_reg, pre_temp_reg, term_pct_reg;
reg [7:0] full_clr_reg, taper_qual_reg, temp_hyst_reg, bal_min_reg;
reg [7:0] bal_period_reg, cell_high_rel_reg;
reg [15:0] rdata_next;

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        cycle_init_reg <= 16'h0000;
        cycle_thr_reg <= 16'h0000;
        chg_volt_reg <= 16'h0000;
        pre_volt_reg <= 16'h0000;
        fast_rate_reg <= 16'h0000;
        maint_rate_reg <= 16'h0000;
        pre_rate_reg <= 16'h0000;
        taper_cur_reg <= 16'h0000;
        overchg_reg <= 16'hFFFF;
        chg_temp_reg <= 16'h7FFF;
        ov_margin_reg <= 16'h0000;
        oc_margin_reg <= 16'h7FFF;
        cell_high_reg <= 16'h0000;
        cell_low_reg <= 16'h0000;
        safe_volt_reg <= 16'hFFFF;
        safe_temp_reg <= 16'h0000;
        cell_low_rel_reg <= 16'h0000;
        bal_start_reg <= `SBC_BAL_OFF;
        eod_thr_reg <= 16'h0000;
        pack_opt_reg <= 8'h00;
        gauge_opt_reg <= 8'h00;
        pre_temp_reg <= 8'h00;
        term_pct_reg <= 8'hFF;
        full_clr_reg <= 8'h00;
        taper_qual_reg <= 8'h00;
        temp_hyst_reg <= 8'h00;
        bal_min_reg <= 8'h00;
        bal_period_reg <= 8'h00;
        cell_high_rel_reg <= 8'h00;
    end
    else if (clk_en && reg_wr)
    begin
        case (reg_addr)
            `SBC_CYCLE_INIT: cycle_init_reg <= reg_wdata;
            `SBC_CYCLE_THR: cycle_thr_reg <= reg_wdata;
            `SBC_CHG_VOLT: chg_volt_reg <= reg_wdata;
            `SBC_PRE_VOLT: pre_volt_reg <= reg_wdata;
            `SBC_FAST_RATE: fast_rate_reg <= reg_wdata;
            `SBC_MAINT_RATE: maint_rate_reg <= reg_wdata;
            `SBC_PRE_RATE: pre_rate_reg <= reg_wdata;
            `SBC_TAPER_CUR: taper_cur_reg <= reg_wdata;
            `SBC_OVERCHG: overchg_reg <= reg_wdata;
            `SBC_CHG_TEMP: chg_temp_reg <= reg_wdata;
            `SBC_OV_MARGIN: ov_margin_reg <= reg_wdata;
            `SBC_OC_MARGIN: oc_margin_reg <= reg_wdata;
            `SBC_CELL_HIGH: cell_high_reg <= reg_wdata;
            `SBC_CELL_LOW: cell_low_reg <= reg_wdata;
            `SBC_SAFE_VOLT: safe_volt_reg <= reg_wdata;
            `SBC_SAFE_TEMP: safe_temp_reg <= reg_wdata;
            `SBC_CELL_LOW_REL: cell_low_rel_reg <= reg_wdata;
            `SBC_BAL_START: bal_start_reg <= reg_wdata;
            `SBC_EOD_THR: eod_thr_reg <= reg_wdata;
            `SBC_PACK_OPT: pack_opt_reg <= reg_wdata[7:0];
            `SBC_GAUGE_OPT: gauge_opt_reg <= {1'b0, reg_wdata[6:0]};
            `SBC_PRE_TEMP: pre_temp_reg <= reg_wdata[7:0];
            `SBC_TERM_PCT: term_pct_reg <= reg_wdata[7:0];
            `SBC_FULL_CLR_PCT: full_clr_reg <= reg_wdata[7:0];
            `SBC_TAPER_QUAL: taper_qual_reg <= reg_wdata[7:0];
            `SBC_TEMP_HYST: temp_hyst_reg <= reg_wdata[7:0];
            `SBC_BAL_MIN: bal_min_reg <= reg_wdata[7:0];
            `SBC_BAL_PERIOD: bal_period_reg <= reg_wdata[7:0];
            `SBC_CELL_HIGH_REL: cell_high_rel_reg <= reg_wdata[7:0];
            default: ;
        endcase
    end
end

// ----------------------------------------
// Option decode
// ----------------------------------------
function [2:0] led_decode;
    input [1:0] bits;
    begin
        case (bits)
            2'b01: led_decode = 3'h3;
            2'b10: led_decode = 3'h4;
            default: led_decode = 3'h5;
        endcase
    end
endfunction

assign display_source_select = pack_opt_reg[`SBC_PACK_DISPLAY_SOURCE_SELECT];
assign led_count = led_decode(pack_opt_reg[`SBC_PACK_LED_COUNT_HIGH:`SBC_PACK_LED_COUNT_LOW]);
assign host_alarm_crc_enable = pack_opt_reg[`SBC_PACK_HPE];
assign charger_broadcast_crc_enable = pack_opt_reg[`SBC_PACK_CPE];
// Driven only from this bit, so battery-mode writes cannot revive it
assign broadcast_enable = ~pack_opt_reg[`SBC_PACK_SM];
// Only the low bit is defined; value 0 means four cells
assign series_cells = pack_opt_reg[0] ? 3'h3 : 3'h4;
assign eod_threshold = gauge_opt_reg[`SBC_GAUGE_EOD_COMPENSATION_ENABLE] ?
    computed_eod_threshold : eod_thr_reg;

// ----------------------------------------
// Charge conditions
// ----------------------------------------
wire [16:0] ov_limit = {1'b0, chg_volt_reg} + {1'b0, ov_margin_reg};
wire [16:0] oc_limit = {1'b0, charge_current_request} + {1'b0, oc_margin_reg};
wire [16:0] taper_floor = {1'b0, chg_volt_reg} - {9'h000, taper_qual_reg};
wire [16:0] temp_release = {chg_temp_reg[15], chg_temp_reg} -
    {9'h000, temp_hyst_reg} * 17'h0000A;
wire [18:0] cell_sum = {3'h0, highest_cell_voltage} * {16'h0000, series_cells};
wire signed [16:0] temp_ext = {temperature[15], temperature};
reg ot_reg, oc_reg, term_reg, taper_reg;
reg [31:0] tick_cnt_reg;
reg [5:0] taper_sec_reg;
reg [7:0] bal_sec_reg;
wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
wire taper_qual = charging && ({1'b0, pack_voltage} >= taper_floor)
    && (pack_current < taper_cur_reg);

assign overvoltage_suspend = charging && ({1'b0, pack_voltage} > ov_limit);
assign overtemp_suspend = ot_reg;
assign overcurrent_suspend = oc_reg;
assign overcharge_suspend = charging && (charge_past_full >= overchg_reg);
assign taper_terminated = taper_reg;

wire suspend = overvoltage_suspend | ot_reg | oc_reg | overcharge_suspend;
wire pre_cond = (pack_voltage < eod_threshold)
    || (temp_ext >= 17'sh00000 && temp_ext < $signed({9'h000, pre_temp_reg}))
    || (pack_voltage < pre_volt_reg);
wire taper_done = taper_qual && !term_reg && taper_sec_reg == `SBC_TAPER_SEC - 1 && tick;
wire term_now = fast_term_event | taper_done;

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        ot_reg <= 1'b0;
        oc_reg <= 1'b0;
        term_reg <= 1'b0;
        taper_reg <= 1'b0;
        tick_cnt_reg <= 32'h00000000;
        taper_sec_reg <= 6'h00;
        bal_sec_reg <= 8'h00;
        balance_start <= 1'b0;
        charge_current_request <= 16'h0000;
        charge_voltage_request <= 16'h0000;
        safety_overvoltage <= 1'b0;
    end
    else if (clk_en)
    begin
        tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
        charge_voltage_request <= chg_volt_reg;
        // Hysteresis held in whole degrees, temperature in tenths
        if (temp_ext > $signed({chg_temp_reg[15], chg_temp_reg}))
            ot_reg <= 1'b1;
        else if (temp_ext <= $signed(temp_release) || temp_ext <= $signed({1'b0, `SBC_TEMP_FLOOR}))
            ot_reg <= 1'b0;
        if (charging && {1'b0, pack_current} >= oc_limit && charge_current_request != 16'h0000)
            oc_reg <= 1'b1;
        else if (!charging)
            oc_reg <= 1'b0;
        // Seconds counter; a voltage dip below the floor or current at or above the limit restarts the 40 s window
        if (!taper_qual)
            taper_sec_reg <= 6'h00;
        else if (tick && taper_sec_reg != `SBC_TAPER_SEC - 1)
            taper_sec_reg <= taper_sec_reg + 6'h01;
        if (taper_done)
            taper_reg <= 1'b1;
        else if (!charging)
            taper_reg <= 1'b0;
        if (term_now)
            term_reg <= 1'b1;
        else if (!charging)
            term_reg <= 1'b0;
        balance_start <= 1'b0;
        if (tick)
        begin
            if (bal_sec_reg != 8'h00)
                bal_sec_reg <= bal_sec_reg - 8'h01;
            else if (bal_start_reg != `SBC_BAL_OFF && highest_cell_voltage >= bal_start_reg
                     && highest_cell_voltage - lowest_cell_voltage >= {8'h00, bal_min_reg})
            begin
                balance_start <= 1'b1;
                bal_sec_reg <= bal_period_reg;
            end
        end
        safety_overvoltage <= gauge_opt_reg[`SBC_GAUGE_OVERVOLTAGE_BASIS_SELECT] ?
            (cell_sum > {3'h0, safe_volt_reg}) : (pack_voltage > safe_volt_reg);
        // Suspension first; once terminated, zero also held while the taper condition lasts
        if (suspend || term_now || (term_reg && taper_qual))
            charge_current_request <= 16'h0000;
        else if (pre_cond)
            charge_current_request <= pre_rate_reg;
        else if (term_reg)
            charge_current_request <= maint_rate_reg;
        else
            charge_current_request <= fast_rate_reg;
    end
end

// ----------------------------------------
// Capacity, full flag and cycle count
// ----------------------------------------
wire [23:0] sync_product = full_charge_capacity * ({8'h00, term_pct_reg} + 16'h0001);
reg [15:0] disch_base_reg;

always @(posedge sys_clk)
begin
    if (!rst_n)
    begin
        remaining_capacity_load <= 1'b0;
        remaining_capacity <= 16'h0000;
        fully_charged <= 1'b0;
        cycle_count <= 16'h0000;
        disch_base_reg <= 16'h0000;
    end
    else if (clk_en)
    begin
        remaining_capacity_load <= term_now && gauge_opt_reg[`SBC_GAUGE_CAPACITY_SYNC_ON_TERMINATION];
        if (term_now && gauge_opt_reg[`SBC_GAUGE_CAPACITY_SYNC_ON_TERMINATION])
            remaining_capacity <= sync_product[23:8];
        // Set wins over clear in the same cycle
        if (full_set_event)
            fully_charged <= 1'b1;
        else if (relative_soc <= full_clr_reg)
            fully_charged <= 1'b0;
        if (reg_wr && reg_addr == `SBC_CYCLE_INIT)
            cycle_count <= reg_wdata;
        else if (cycle_thr_reg != 16'h0000 && discharged_mah - disch_base_reg >= cycle_thr_reg)
        begin
            cycle_count <= cycle_count + 16'h0001;
            disch_base_reg <= disch_base_reg + cycle_thr_reg;
        end
    end
end

// ----------------------------------------
// Read port
// ----------------------------------------
always @*
begin
    case (reg_addr)
        `SBC_CYCLE_INIT: rdata_next = cycle_init_reg;
        `SBC_CYCLE_THR: rdata_next = cycle_thr_reg;
        `SBC_CHG_VOLT: rdata_next = chg_volt_reg;
        `SBC_PRE_VOLT: rdata_next = pre_volt_reg;
        `SBC_FAST_RATE: rdata_next = fast_rate_reg;
        `SBC_MAINT_RATE: rdata_next = maint_rate_reg;
        `SBC_PRE_RATE: rdata_next = pre_rate_reg;
        `SBC_TAPER_CUR: rdata_next = taper_cur_reg;
        `SBC_OVERCHG: rdata_next = overchg_reg;
        `SBC_CHG_TEMP: rdata_next = chg_temp_reg;
        `SBC_OV_MARGIN: rdata_next = ov_margin_reg;
        `SBC_OC_MARGIN: rdata_next = oc_margin_reg;
        `SBC_CELL_HIGH: rdata_next = cell_high_reg;
        `SBC_CELL_LOW: rdata_next = cell_low_reg;
        `SBC_SAFE_VOLT: rdata_next = safe_volt_reg;
        `SBC_SAFE_TEMP: rdata_next = safe_temp_reg;
        `SBC_CELL_LOW_REL: rdata_next = cell_low_rel_reg;
        `SBC_BAL_START: rdata_next = bal_start_reg;
        `SBC_EOD_THR: rdata_next = eod_thr_reg;
        `SBC_PACK_OPT: rdata_next = {8'h00, pack_opt_reg};
        `SBC_GAUGE_OPT: rdata_next = {8'h00, gauge_opt_reg};
        `SBC_PRE_TEMP: rdata_next = {8'h00, pre_temp_reg};
        `SBC_TERM_PCT: rdata_next = {8'h00, term_pct_reg};
        `SBC_FULL_CLR_PCT: rdata_next = {8'h00, full_clr_reg};
        `SBC_TAPER_QUAL: rdata_next = {8'h00, taper_qual_reg};
        `SBC_TEMP_HYST: rdata_next = {8'h00, temp_hyst_reg};
        `SBC_BAL_MIN: rdata_next = {8'h00, bal_min_reg};
        `SBC_BAL_PERIOD: rdata_next = {8'h00, bal_period_reg};
        `SBC_CELL_HIGH_REL: rdata_next = {8'h00, cell_high_rel_reg};
        `SBC_STATUS: rdata_next = {8'h00, safety_overvoltage, fully_charged, taper_reg,
            term_reg, overcharge_suspend, oc_reg, ot_reg, overvoltage_suspend};
        `SBC_CYCLE_CNT: rdata_next = cycle_count;
        `SBC_REQ_CUR: rdata_next = charge_current_request;
        default: rdata_next = 16'h0000;
    endcase
end

always @(posedge sys_clk)
begin
    if (!rst_n)
        reg_rdata <= 16'h0000;
    else if (clk_en)
        reg_rdata <= reg_rd ? rdata_next : 16'h0000;
end

endmodule

// [tb/sbc_charge_ctrl_asserts.sv]
/*
 Checker for the charge-control block: suspension, option decode, pulses, counts.
 Assumes only the top module's ports; bound at the foot of this file.
*/
`timescale 1ns/1ps
module sbc_charge_ctrl_asserts
(
    // Clock, reset and register port
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    // Watched
    input wire signed [15:0] temperature,
    input wire [15:0] charge_current_request,
    input wire remaining_capacity_load,
    input wire [15:0] cycle_count,
    input wire balance_start,
    input wire overvoltage_suspend,
    input wire overtemp_suspend,
    input wire overcurrent_suspend,
    input wire overcharge_suspend,
    input wire display_source_select,
    input wire [2:0] led_count,
    input wire host_alarm_crc_enable,
    input wire charger_broadcast_crc_enable,
    input wire broadcast_enable,
    input wire [2:0] series_cells
);
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    wire susp = overvoltage_suspend | overtemp_suspend | overcurrent_suspend | overcharge_suspend;
    wire pack_wr = clk_en & reg_wr & (reg_addr == 8'h28);

    AST_SUSPEND_WINS: assert property ((clk_en && susp) [*2] |=>
        charge_current_request == 16'h0000) else $error("request not zero under suspension");
    AST_LOAD_PULSE: assert property (remaining_capacity_load |=>
        !remaining_capacity_load) else $error("capacity load longer than one cycle");
    AST_BAL_PULSE: assert property ($rose(balance_start) |=>
        $fell(balance_start)) else $error("balance start longer than one cycle");
    AST_DISPLAY_SRC: assert property (pack_wr |=>
        display_source_select == $past(reg_wdata[7])) else $error("display source wrong");
    AST_LED_SIZE: assert property (pack_wr |=> led_count ==
        (($past(reg_wdata[6:5]) == 2'h1) ? 3'h3 : ($past(reg_wdata[6:5]) == 2'h2) ? 3'h4 : 3'h5))
        else $error("led count wrong");
    AST_CRC_BITS: assert property (pack_wr |=>
        {host_alarm_crc_enable, charger_broadcast_crc_enable} == $past(reg_wdata[4:3]))
        else $error("crc enables wrong");
    AST_BCAST_OFF: assert property ((pack_wr && reg_wdata[2]) ##1 (!pack_wr) [*4] |=>
        !broadcast_enable) else $error("broadcast enabled while disabled");
    AST_CELLS: assert property (pack_wr |=>
        series_cells == ($past(reg_wdata[0]) ? 3'h3 : 3'h4)) else $error("series cells wrong");
    AST_OT_CLEAR: assert property ((temperature <= 16'sh01AE) [*2] |->
        !overtemp_suspend) else $error("overtemperature kept at low temperature");
    AST_CYCLE_STEP: assert property (!$past(reg_wr) && $changed(cycle_count) |->
        cycle_count == $past(cycle_count) + 16'h0001) else $error("cycle count jumped");
endmodule
bind sbc_charge_ctrl sbc_charge_ctrl_asserts u_sbc_charge_ctrl_asserts (.sys_clk, .rst_n,
    .clk_en, .reg_addr, .reg_wdata, .reg_wr, .temperature, .charge_current_request,
    .remaining_capacity_load, .cycle_count, .balance_start, .overvoltage_suspend,
    .overtemp_suspend, .overcurrent_suspend, .overcharge_suspend, .display_source_select,
    .led_count, .host_alarm_crc_enable, .charger_broadcast_crc_enable, .broadcast_enable,
    .series_cells);

// [tb/sbc_charger_model.sv]
/*
 Behavioural charger: delivers the requested current, promptly or after a lag.
 Assumes the bench steers it; excess current is only added when a scenario asks.
*/
`timescale 1ns/1ps
module sbc_charger_model
(
    // Clock and bench control
    input wire sys_clk,
    input wire active,
    input wire slow,
    input wire [15:0] excess,
    // Device side
    input wire [15:0] charge_current_request,
    output reg [15:0] pack_current,
    output reg charging
);
    reg [3:0] lag_reg;
    initial
    begin
        lag_reg = 4'h0;
        pack_current = 16'h0000;
        charging = 1'b0;
    end
    always @(posedge sys_clk)
    begin
        charging <= active;
        lag_reg <= slow ? lag_reg + 4'h1 : 4'h0;
        // Slow charger only follows every sixteenth cycle
        if (!active)
            pack_current <= 16'h0000;
        else if (!slow || lag_reg == 4'hF)
            pack_current <= charge_current_request + excess;
    end
endmodule

// [tb/test_smart_battery_charge_control.sv]
/*
 Self-checking bench: register reads queued and compared by a monitor.
 Assumes the charger model and the bound checker; one-second tick shortened to 10 cycles.
*/
`timescale 1ns/1ps
module test_smart_battery_charge_control;
    reg sys_clk, rst_n, reg_wr, reg_rd, fast_term_event, full_set_event, chg_on, chg_slow, rd_seen;
    reg [7:0] reg_addr, relative_soc, absolute_soc;
    reg [15:0] reg_wdata, pack_voltage, hi_cell, lo_cell, eod_calc, charge_past_full, discharged_mah;
    reg [15:0] excess, fr;
    reg signed [15:0] temperature;
    reg [31:0] rng;
    wire [15:0] reg_rdata, pack_current, cv_req, ci_req, rm, eod_out;
    wire charging, rm_load;
    integer bad_count, n_tests, cyc, k;
    reg [15:0] exp_q[$];
    localparam [24*17-1:0] CFG = {
        24'h393138, 24'h5A0064, 24'h3B2328, 24'h410190, 24'h3F0032, 24'h430064,
        24'hF01F40, 24'h5C00C8, 24'h2900C0, 24'h46007F, 24'h5301F4, 24'h550003,
        24'h4E03E8, 24'h470032, 24'h370064, 24'h4803E8, 24'h4A0064};

    sbc_charge_ctrl #(.TICK_CYCLES(10)) u_sbc_charge_ctrl (.sys_clk, .rst_n, .clk_en(1'b1),
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pack_voltage, .pack_current,
        .charging, .temperature, .highest_cell_voltage(hi_cell), .lowest_cell_voltage(lo_cell),
        .computed_eod_threshold(eod_calc), .full_charge_capacity(16'h0FA0), .relative_soc,
        .absolute_soc, .charge_past_full, .discharged_mah, .fast_term_event, .full_set_event,
        .charge_voltage_request(cv_req), .charge_current_request(ci_req),
        .remaining_capacity_load(rm_load), .remaining_capacity(rm), .fully_charged(),
        .cycle_count(), .balance_start(), .safety_overvoltage(), .overvoltage_suspend(),
        .overtemp_suspend(), .overcurrent_suspend(), .overcharge_suspend(), .taper_terminated(),
        .display_source_select(), .led_count(), .host_alarm_crc_enable(),
        .charger_broadcast_crc_enable(), .broadcast_enable(), .series_cells(),
        .eod_threshold(eod_out));
    sbc_charger_model u_sbc_charger_model (.sys_clk, .active(chg_on), .slow(chg_slow), .excess,
        .charge_current_request(ci_req), .pack_current, .charging);

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [15:0] wm(input [7:0] a);
        wm = (a == 8'h29) ? 16'h007F : (a == 8'h43 || a == 8'h46 || a == 8'h47 ||
            a == 8'h4A || a == 8'h55) ? 16'h00FF : 16'hFFFF;
    endfunction
    task automatic check(input [8*8:1] what, input [15:0] e, input [15:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== e)
            begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s exp %h got %h", what, e, got);
            end
        end
    endtask
    task idle(input integer n);
        begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            repeat (n) @(posedge sys_clk);
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            reg_wr <= 1'b1;
            reg_rd <= 1'b0;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge sys_clk);
        end
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            reg_rd <= 1'b1;
            reg_wr <= 1'b0;
            reg_addr <= a;
            exp_q.push_back(e);
            @(posedge sys_clk);
        end
    endtask
    // Settle, then read back the request or the status word
    task req(input [15:0] e);
        begin
            idle(4);
            rd(8'hF3, e);
        end
    endtask
    task stat(input [15:0] e);
        begin
            idle(4);
            rd(8'hF1, e);
        end
    endtask
    task config_all;
        integer i;
        begin
            for (i = 0; i < 17; i = i + 1)
                wr(CFG[i*24+16+:8], CFG[i*24+:16]);
            for (i = 0; i < 17; i = i + 1)
                rd(CFG[i*24+16+:8], CFG[i*24+:16] & wm(CFG[i*24+16+:8]));
            rd(8'h01, 16'h0000);
            fr = {7'h00, rng[8:0]} + 16'h0100;
            wr(8'h3D, fr);
        end
    endtask
    task do_reset;
        begin
            rst_n <= 1'b0;
            idle(12);
            rst_n <= 1'b1;
        end
    endtask
    task summarize;
        begin
            if (bad_count == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Monitor: oldest queued note against each read answer
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (rd_seen)
            check("rdata", exp_q.pop_front(), reg_rdata);
        rd_seen <= reg_rd;
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            bad_count = bad_count + 1;
            summarize;
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        rng = 32'h4CAE;
        {bad_count, n_tests, cyc} = 0;
        {rst_n, reg_wr, reg_rd, rd_seen, fast_term_event, full_set_event, chg_slow} = 7'h00;
        {reg_addr, reg_wdata, charge_past_full, discharged_mah, excess} = 0;
        chg_on = 1'b1;
        pack_voltage = 16'd12000;
        temperature = 16'sd250;
        relative_soc = 8'h5A;
        {absolute_soc, hi_cell, lo_cell, eod_calc} = {rng[7:0], rng[15:0], 8'h00, rng[7:0],
            16'h1F00};
        do_reset;
        rd(8'hF3, 16'h0000);
        rd(8'hF2, 16'h0000);
        config_all;
        for (k = 0; k < 8; k = k + 1)
        begin
            rng = xs(rng);
            wr(8'h28, {8'h00, rng[7:0]});
        end
        idle(6);
        rd(8'h28, {8'h00, rng[7:0]});
        req(fr);
        check("volt_req", 16'h3138, cv_req);
        pack_voltage <= 16'd8500;
        req(16'h0190);
        wr(8'hF0, 16'h2710);
        pack_voltage <= 16'd9500;
        req(16'h0190);
        check("eod", 16'h2710, eod_out);
        pack_voltage <= 16'd12000;
        temperature <= 16'sd50;
        req(16'h0190);
        temperature <= 16'sd250;
        pack_voltage <= 16'd12700;
        req(fr);
        pack_voltage <= 16'd12701;
        stat(16'h0001);
        temperature <= 16'sd50;
        req(16'h0000);
        {pack_voltage, temperature} <= {16'd12000, 16'sd501};
        stat(16'h0002);
        temperature <= 16'sd480;
        stat(16'h0002);
        temperature <= 16'sd469;
        stat(16'h0000);
        req(fr);
        {chg_slow, excess} <= {1'b1, 16'h00C8};
        idle(24);
        stat(16'h0004);
        {chg_slow, excess, chg_on} <= {1'b0, 16'h0000, 1'b0};
        idle(4);
        chg_on <= 1'b1;
        req(fr);
        charge_past_full <= 16'd1001;
        stat(16'h0008);
        req(16'h0000);
        charge_past_full <= 16'd0;
        full_set_event <= 1'b1;
        idle(1);
        full_set_event <= 1'b0;
        stat(16'h0040);
        relative_soc <= 8'h32;
        stat(16'h0000);
        fast_term_event <= 1'b1;
        idle(1);
        fast_term_event <= 1'b0;
        for (k = 0; k < 20 && rm_load !== 1'b1; k = k + 1)
            @(posedge sys_clk);
        check("rm_load", 1'b1, rm_load);
        check("rm", 16'd2000, rm);
        check("ci_req", 16'h0000, ci_req);
        req(16'h0032);
        do_reset;
        config_all;
        wr(8'hD9, 16'h0000);
        wr(8'h0C, 16'h0005);
        discharged_mah <= 16'd100;
        idle(4);
        rd(8'hF2, 16'h0006);
        discharged_mah <= 16'd199;
        idle(4);
        rd(8'hF2, 16'h0006);
        discharged_mah <= 16'd200;
        idle(4);
        rd(8'hF2, 16'h0007);
        wr(8'h29, 16'h0050);
        idle(1);
        check("eod", 16'h1F00, eod_out);
        pack_voltage <= 16'd12550;
        idle(380);
        stat(16'h0000);
        idle(60);
        stat(16'h0030);
        req(16'h0000);
        idle(4);
        summarize;
    end
endmodule
